/* logic/angle_path_safety_monitor_consts.vh */
// Constants for the angle path safety monitor: register map, field
// positions, reset values, flag numbering and sequencer timing.
// Assumes a 25 MHz core clock and a byte-addressed register port.
`ifndef ANGLE_PATH_SAFETY_MONITOR_CONSTS_VH
`define ANGLE_PATH_SAFETY_MONITOR_CONSTS_VH

// Register byte offsets
`define REG_SETTINGS 8'h00
`define REG_FLAGS 8'h04
`define REG_IRQ_STATUS 8'h08
`define REG_IRQ_MASK 8'h0c
`define REG_SEQ_STATE 8'h10

// Safety settings register fields
`define SET_BIST_EN 0
`define SET_DIS_LO 1
`define SET_MASK_LO 8
`define SET_WIDTH 15
`define SET_RESET 15'h0001

// Failure flag positions
`define FL_FIELD 0
`define FL_INV 1
`define FL_DIV 2
`define FL_CONV 3
`define FL_ADJ 4
`define FL_CTRL 5
`define FL_COMPL 6
`define FL_ENC 7
`define FL_ADC 8
`define FL_ADDER 9
`define FL_CORDIC 10
`define FL_ANGRNG 11
`define FL_TSENS 12
`define FL_NOREADY 13
`define FL_WIDTH 14
`define NUM_TESTS 5

// Check thresholds
`define TEMP_TOL 12'h020
`define DIV_KNOWN_RESULT 16'h5555
`define ADC_LIMIT 16'hf332

// Sequencer timing: one full round of 16 slots takes 2.08 ms
`define CLK_PERIOD_NS 40
`define ROUND_NS 2080000
`define ROUND_CYC (`ROUND_NS / `CLK_PERIOD_NS)
`define NUM_SLOTS 16

`endif

/* logic/angle_path_safety_monitor.v */
// Safety self-check unit for the angle data path: sequenced built-in tests,
// always-running range and sequencing monitors, sticky flags, diagnostic request.
// Assumes all inputs are synchronous to clock and the register port master
// never issues read and write strobes together.
//
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`include "angle_path_safety_monitor_consts.vh"

module angle_path_safety_monitor #(
    parameter ROUND_CYC = `ROUND_CYC
) (
    input wire clock,
    input wire nrst,
    // Register port: byte address, one-cycle strobes, read data a cycle later
    input wire [7:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    // Built-in test handshake with the angle data path, one bit per test
    output reg [4:0] test_start,
    input wire [4:0] test_ready,
    // Operands of the built-in tests, looked at only in the ready cycle; temp_sensor_fault is watched on every cycle
    input wire [11:0] temp_chip,
    input wire [11:0] temp_amp,
    input wire temp_sensor_fault,
    input wire [15:0] main_angle,
    input wire [15:0] inv_angle,
    input wire [15:0] clamp_lo,
    input wire [15:0] clamp_hi,
    input wire [15:0] div_result,
    input wire [15:0] cordic_angle,
    input wire [15:0] inv_cordic_angle,
    input wire [15:0] zeroed_angle,
    input wire [15:0] alu_zeroed_angle,
    // Fixed monitor inputs, watched on every cycle
    input wire ctrl_path_error,
    input wire adc_valid,
    input wire [15:0] adc_filtered,
    input wire pre_add_valid,
    input wire [15:0] pre_add_a,
    input wire [15:0] pre_add_b,
    input wire cordic_overflow,
    input wire sweep_start,
    input wire range_hit,
    input wire clamp_hit,
    // Diagnostic request to the output stage and the interrupt line
    output reg diag_req,
    output reg irq
);

    // Slot length derived from the round time, rounded down; any remainder
    // of the round is lost, so a round may end a few cycles early
    localparam integer SLOT_INT = ROUND_CYC / `NUM_SLOTS;
    // The slot counter is 16 bits wide, which bounds the round length
    localparam [15:0] SLOT_CYC = SLOT_INT[15:0];

    // Sequencer phase: one-hot, idle while the global enable is clear
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_RUN = 2'b10;

    reg [1:0] phase_q;           // Sequencer phase
    reg [15:0] slot_cnt_q;       // Cycles within current slot
    reg [3:0] seq_cnt_q;         // Slot number
    reg seq_par_q;               // Parity bit kept beside the slot number
    reg [`SET_WIDTH-1:0] settings_q;  // Safety settings register
    reg [`FL_WIDTH-1:0] flags_q;      // Sticky failure flags
    reg [`FL_WIDTH-1:0] irq_stat_q;   // Interrupt status, read clears
    reg [`FL_WIDTH-1:0] irq_mask_q;   // Interrupt mask
    reg [`NUM_TESTS-1:0] test_fail_q; // A test failed in this slot
    reg range_seen_q;            // Range position seen in this sweep
    reg [`FL_WIDTH-1:0] set_ev;  // Flags raised this cycle

    // Field decoding of the settings register. Disables and masks act only
    // on the setting of a flag; a flag already stored stays until reset,
    // so software cannot hide a fault by masking it afterwards.
    wire bist_en = settings_q[`SET_BIST_EN];
    wire [`NUM_TESTS-1:0] test_dis = settings_q[`SET_DIS_LO +: `NUM_TESTS];
    wire [6:0] mon_mask = settings_q[`SET_MASK_LO +: 7];
    // Last cycle of a slot; triggers still up here are cut and reported
    wire slot_end = (slot_cnt_q == SLOT_CYC - 16'h0001);
    // The angle sums are kept at 17 bits so that a carry out of either
    // side can never make two different sums compare equal
    wire [16:0] angle_sum = {1'b0, main_angle} + {1'b0, inv_angle};
    wire [16:0] clamp_sum = {1'b0, clamp_lo} + {1'b0, clamp_hi};
    // Angles wrap at full turn, so the rotation core sum is taken modulo 2^16
    wire [15:0] cordic_sum = cordic_angle + inv_cordic_angle;
    // Both adder paths are rebuilt here only to judge their sign bits;
    // the real adder sits in the data path, this is a shadow of it
    wire [15:0] pre_add_sum = pre_add_a + pre_add_b;
    wire [15:0] pre_add_sum_sub = pre_add_a - pre_add_b;

    // Signed overflow of an addition, shared by both adder checks.
    // Overflow shows when both operands share a sign the result lacks;
    // for a difference the caller passes the inverted sign of b.
    function add_ovf;
        input sa;
        input sb;
        input ss;
        begin
            add_ovf = (sa == sb) && (ss != sa);
        end
    endfunction

    // Absolute difference above a tolerance. A difference exactly on the
    // tolerance still passes, which leaves a little room for sensor noise.
    function temp_off;
        input [11:0] a;
        input [11:0] b;
        begin
            if (a > b) begin
                temp_off = (a - b) > `TEMP_TOL;
            end else begin
                temp_off = (b - a) > `TEMP_TOL;
            end
        end
    endfunction

    // Sequencer phase and slot counter. Clearing the global enable drops
    // the sequencer back to idle at once, so a round in progress is lost;
    // the parity bit is rebuilt from the next count so it never lags it.
    // slot up-counter
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            phase_q <= ST_IDLE;
            slot_cnt_q <= 16'h0000;
            seq_cnt_q <= 4'h0;
            seq_par_q <= 1'b0;
        end else begin
            case (phase_q)
                ST_IDLE: begin
                    if (bist_en) begin
                        phase_q <= ST_RUN;
                    end
                    slot_cnt_q <= 16'h0000;
                    seq_cnt_q <= 4'h0;
                    seq_par_q <= 1'b0;
                end
                ST_RUN: begin
                    if (!bist_en) begin
                        phase_q <= ST_IDLE;
                    end else if (slot_end) begin
                        // Wraps after 16 slots; parity follows the new count
                        slot_cnt_q <= 16'h0000;
                        seq_cnt_q <= seq_cnt_q + 4'h1;
                        seq_par_q <= ^(seq_cnt_q + 4'h1);
                    end else begin
                        slot_cnt_q <= slot_cnt_q + 16'h0001;
                    end
                end
                default: begin
                    phase_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Start triggers: slot k (1..5) launches test k-1, ready clears it.
    // A trigger never outlives its slot, so at most one test is in flight
    // and a late ready from a cut test cannot be taken for the next one.
    // A disable written while a test runs takes effect from the next round.
    // per-test disable
    always @(posedge clock or negedge nrst) begin : start_proc
        integer i;
        if (!nrst) begin
            test_start <= 5'h00;
        end else begin
            for (i = 0; i < `NUM_TESTS; i = i + 1) begin
                if (phase_q != ST_RUN || slot_end) begin
                    test_start[i] <= 1'b0;
                end else if (slot_cnt_q == 16'h0000 && seq_cnt_q == i + 1 && !test_dis[i]) begin
                    test_start[i] <= 1'b1;
                end else if (test_ready[i]) begin
                    test_start[i] <= 1'b0;
                end
            end
        end
    end

    // Result checks, taken when a running test reports ready. Operands are
    // judged only in the ready cycle; outside it they may change freely.
    // Fixed monitors look at their inputs on every cycle instead.
    always @* begin
        set_ev = {`FL_WIDTH{1'b0}};
        set_ev[`FL_FIELD] = test_start[0] && test_ready[0] && temp_off(temp_chip, temp_amp);
        set_ev[`FL_INV] = test_start[1] && test_ready[1] && (angle_sum != clamp_sum);
        set_ev[`FL_DIV] = test_start[2] && test_ready[2] && (div_result != `DIV_KNOWN_RESULT);
        set_ev[`FL_CONV] = test_start[3] && test_ready[3] && (cordic_sum != 16'h0000);
        set_ev[`FL_ADJ] = test_start[4] && test_ready[4] && (zeroed_angle != alu_zeroed_angle);
        set_ev[`FL_CTRL] = ctrl_path_error && !mon_mask[0];
        // failure reported at slot end, well within one round
        set_ev[`FL_COMPL] = slot_end && phase_q == ST_RUN
            && ((|test_fail_q) || (|test_start)) && !mon_mask[1];
        set_ev[`FL_ENC] = ((^{seq_par_q, seq_cnt_q}) || (phase_q != ST_IDLE && phase_q != ST_RUN))
            && !mon_mask[2];
        set_ev[`FL_ADC] = adc_valid && (adc_filtered > `ADC_LIMIT) && !mon_mask[3];
        // pre-rotation adder overflow, sum and difference paths
        set_ev[`FL_ADDER] = pre_add_valid && !mon_mask[4]
            && (add_ovf(pre_add_a[15], pre_add_b[15], pre_add_sum[15])
            || add_ovf(pre_add_a[15], ~pre_add_b[15], pre_add_sum_sub[15]));
        set_ev[`FL_CORDIC] = cordic_overflow && !mon_mask[5];
        set_ev[`FL_ANGRNG] = clamp_hit && !range_seen_q && !range_hit && !mon_mask[6];
        set_ev[`FL_TSENS] = temp_sensor_fault;
        // ready still missing when the slot ends
        set_ev[`FL_NOREADY] = slot_end && phase_q == ST_RUN && (|test_start);
    end

    // Per-slot test failure memory feeding the completion monitor.
    // Cleared at each slot end, after the completion check has seen it.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            test_fail_q <= 5'h00;
        end else if (slot_end || phase_q != ST_RUN) begin
            test_fail_q <= 5'h00;
        end else begin
            test_fail_q <= test_fail_q | set_ev[`NUM_TESTS-1:0];
        end
    end

    // Range position tracking for the angular range monitor.
    // A new sweep wins over a range hit in the same cycle: the hit is
    // taken to belong to the sweep that just ended.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            range_seen_q <= 1'b0;
        end else if (sweep_start) begin
            range_seen_q <= 1'b0;
        end else if (range_hit) begin
            range_seen_q <= 1'b1;
        end
    end

    // Sticky flags and merged diagnostic request. The request is built
    // from the flags and this cycle's events, so it comes one cycle after
    // the event and never waits for the flag register itself.
    // held until reset
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            flags_q <= {`FL_WIDTH{1'b0}};
            diag_req <= 1'b0;
        end else begin
            flags_q <= flags_q | set_ev;
            // Masking happens at the set, so every stored flag counts
            diag_req <= |(flags_q | set_ev);
        end
    end

    // Register writes and interrupt status. The status copy is separate
    // from the sticky flags so that software can clear it by reading
    // without touching the diagnostic request.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            settings_q <= `SET_RESET;
            irq_mask_q <= {`FL_WIDTH{1'b0}};
            irq_stat_q <= {`FL_WIDTH{1'b0}};
            irq <= 1'b0;
        end else begin
            if (wr && addr == `REG_SETTINGS) begin
                settings_q <= wdata[`SET_WIDTH-1:0];
            end
            if (wr && addr == `REG_IRQ_MASK) begin
                irq_mask_q <= wdata[`FL_WIDTH-1:0];
            end
            // Read clears, but a new event in the same cycle survives
            if (rd && addr == `REG_IRQ_STATUS) begin
                irq_stat_q <= set_ev;
            end else begin
                irq_stat_q <= irq_stat_q | set_ev;
            end
            irq <= |(irq_stat_q & irq_mask_q);
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    // Driven to zero otherwise, so a shared read bus can simply OR it.
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `REG_SETTINGS: rdata <= {17'h00000, settings_q};
                `REG_FLAGS: rdata <= {18'h00000, flags_q};
                `REG_IRQ_STATUS: rdata <= {18'h00000, irq_stat_q};
                `REG_IRQ_MASK: rdata <= {18'h00000, irq_mask_q};
                `REG_SEQ_STATE: rdata <= {25'h0000000, phase_q == ST_RUN, 1'b0, seq_par_q,
                    seq_cnt_q};
                // Unmapped addresses read as zero
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

endmodule

/* verification/angle_path_safety_monitor_checker.sv */
// Checker for the angle path safety monitor: test handshake and diagnostic timing.
// Assumes it is bound to the monitor and sees only its ports.
`timescale 1ns/1ns
`include "angle_path_safety_monitor_consts.vh"
module angle_path_safety_monitor_checker #(
    parameter ROUND_CYC = 160
) (
    input wire clock,
    input wire nrst,
    input wire [4:0] test_start,
    input wire [4:0] test_ready,
    input wire temp_sensor_fault,
    input wire [15:0] main_angle,
    input wire [15:0] inv_angle,
    input wire [15:0] clamp_lo,
    input wire [15:0] clamp_hi,
    input wire [15:0] div_result,
    input wire [15:0] cordic_angle,
    input wire [15:0] inv_cordic_angle,
    input wire [15:0] zeroed_angle,
    input wire [15:0] alu_zeroed_angle,
    input wire diag_req
);
    localparam int SLOT = ROUND_CYC / 16;
    // Tests whose ready is being sampled this cycle
    wire [4:0] ack = test_start & test_ready;
    // Cycles the current start trigger has stood
    reg [15:0] run_q;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    // A trigger may never outlive its slot
    always @(posedge clock or negedge nrst) begin
        if (!nrst)
            run_q <= 16'h0;
        else
            run_q <= (|test_start) ? run_q + 16'h1 : 16'h0;
    end
    AST_DIAG_HOLD: assert property (diag_req |=> diag_req)
        else $error("diag_req dropped before reset");
    AST_TSENS: assert property (temp_sensor_fault |-> ##2 diag_req)
        else $error("sensor fault without diag_req");
    AST_READY_CLR: assert property (|ack |=> test_start == 5'h0)
        else $error("start not cleared by ready");
    AST_ONE_TEST: assert property ($onehot0(test_start))
        else $error("two tests started together");
    AST_SLOT_LEN: assert property (run_q <= SLOT)
        else $error("start outlived its slot");
    AST_NO_READY: assert property ($fell(|test_start) && !$past(|ack) |-> ##[0:2] diag_req)
        else $error("missing ready without diag_req");
    AST_INV_SUM: assert property (ack[1] &&
        ({1'b0, main_angle} + inv_angle != {1'b0, clamp_lo} + clamp_hi) |-> ##2 diag_req)
        else $error("inverse sum fault missed");
    AST_DIV: assert property (ack[2] && div_result != `DIV_KNOWN_RESULT |-> ##2 diag_req)
        else $error("division fault missed");
    AST_CONV: assert property (ack[3] && (cordic_angle + inv_cordic_angle != 16'h0)
        |-> ##2 diag_req) else $error("conversion fault missed");
    AST_ADJ: assert property (ack[4] && zeroed_angle != alu_zeroed_angle |-> ##2 diag_req)
        else $error("adjusted angle fault missed");
endmodule
bind angle_path_safety_monitor angle_path_safety_monitor_checker #(.ROUND_CYC(ROUND_CYC)) chk (
    .clock(clock), .nrst(nrst), .test_start(test_start), .test_ready(test_ready),
    .temp_sensor_fault(temp_sensor_fault), .main_angle(main_angle), .inv_angle(inv_angle),
    .clamp_lo(clamp_lo), .clamp_hi(clamp_hi), .div_result(div_result),
    .cordic_angle(cordic_angle), .inv_cordic_angle(inv_cordic_angle),
    .zeroed_angle(zeroed_angle), .alu_zeroed_angle(alu_zeroed_angle), .diag_req(diag_req));

/* verification/angle_path_model.sv */
// Model of the angle data path answering the monitor's test triggers.
// Assumes bad selects wrong operands per test and mute withholds ready.
`timescale 1ns/1ns
module angle_path_model (
    input wire clock,
    input wire nrst,
    input wire [4:0] test_start,
    input wire [4:0] bad,
    input wire [4:0] mute,
    output reg [4:0] test_ready,
    output reg [11:0] temp_chip,
    output reg [11:0] temp_amp,
    output reg [15:0] main_angle,
    output reg [15:0] inv_angle,
    output reg [15:0] clamp_lo,
    output reg [15:0] clamp_hi,
    output reg [15:0] div_result,
    output reg [15:0] cordic_angle,
    output reg [15:0] inv_cordic_angle,
    output reg [15:0] zeroed_angle,
    output reg [15:0] alu_zeroed_angle
);
    integer seed = 20;
    integer i;
    reg [31:0] rv;
    reg [31:0] rw;
    // Tests already answered in their slot
    reg [4:0] done_q;
    // Fresh operands each cycle; clamp sums kept within 16 bits so no carry is lost
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            test_ready <= 5'h0;
            done_q <= 5'h0;
        end else begin
            rv = $random(seed);
            rw = $random(seed);
            // Temperature difference sits exactly on the tolerance edge
            temp_chip <= {1'b0, rv[10:0]};
            temp_amp <= {1'b0, rv[10:0]} + (bad[0] ? 12'h021 : 12'h020);
            clamp_lo <= {1'b0, rv[14:0]};
            clamp_hi <= {1'b0, rv[29:15]};
            main_angle <= {1'b0, rv[14:0]} + ({1'b0, rv[29:15]} & rw[31:16]);
            inv_angle <= {1'b0, rv[29:15]} - ({1'b0, rv[29:15]} & rw[31:16]) + bad[1];
            div_result <= 16'h5555 ^ {15'h0, bad[2]};
            cordic_angle <= rw[15:0];
            inv_cordic_angle <= 16'h0 - rw[15:0] + bad[3];
            zeroed_angle <= rw[15:0];
            alu_zeroed_angle <= rw[15:0] ^ {15'h0, bad[4]};
            test_ready <= 5'h0;
            done_q <= done_q & test_start;
            for (i = 0; i < 5; i = i + 1) begin
                if (test_start[i] && !done_q[i] && !mute[i] && rw[2 * i +: 2] != 2'b00) begin
                    test_ready[i] <= 1'b1;
                    done_q[i] <= 1'b1;
                end
            end
        end
    end
endmodule

/* verification/angle_path_safety_monitor_tb.sv */
// Self-checking bench for the angle path safety monitor.
// Assumes the data path model answers triggers; registers go over the plain port.
`timescale 1ns/1ns
`include "angle_path_safety_monitor_consts.vh"
module angle_path_safety_monitor_tb;
    localparam int ROUND = 160;
    reg clock = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, temp_sensor_fault = 1'b0;
    reg ctrl_path_error = 1'b0, adc_valid = 1'b0, pre_add_valid = 1'b0, cordic_overflow = 1'b0;
    reg sweep_start = 1'b0, range_hit = 1'b0, clamp_hit = 1'b0;
    reg [7:0] addr = 8'h00;
    reg [31:0] wdata = 32'h0, expf;
    reg [15:0] adc_filtered = 16'h0, pre_add_a = 16'h0, pre_add_b = 16'h0;
    reg [4:0] bad = 5'h0, mute = 5'h0;
    wire [31:0] rdata;
    wire [4:0] test_start, test_ready;
    wire [11:0] temp_chip, temp_amp;
    wire [15:0] main_angle, inv_angle, clamp_lo, clamp_hi, div_result, cordic_angle;
    wire [15:0] inv_cordic_angle, zeroed_angle, alu_zeroed_angle;
    wire diag_req, irq;
    integer error_cnt = 0, tests_run = 0, cyc = 0, hi_cnt = 0, k, zc;
    angle_path_safety_monitor #(.ROUND_CYC(ROUND)) dut (.*);
    angle_path_model model (.*);
    initial forever #20 clock = ~clock;
    // Cut a hang short
    always @(posedge clock) begin
        cyc = cyc + 1;
        if (cyc == 20000) begin
            error_cnt = error_cnt + 1;
            finish_test;
        end
    end
    task finish_test;
        if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input string n, input [31:0] e, input [31:0] g);
        tests_run = tests_run + 1;
        if (g !== e) begin
            error_cnt = error_cnt + 1;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    // One-cycle strobes; read data stand only in the following cycle
    task wr_reg(input [7:0] a, input [31:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task rd_chk(input [7:0] a, input [31:0] e);
        @(posedge clock);
        addr <= a;
        rd <= 1'b1;
        @(posedge clock);
        rd <= 1'b0;
        #1 chk("rdata", e, rdata);
    endtask
    // Counts cycles with any trigger up
    task run(input integer n);
        hi_cnt = 0;
        repeat (n) @(negedge clock) hi_cnt = hi_cnt + (|test_start);
    endtask
    // Wait until no test is in flight, so operand changes never hit a live test
    // 30 idle cycles exceed any gap inside the test slots, so we sit in the idle tail
    task quiet;
        zc = 0;
        while (zc < 30) begin
            @(posedge clock);
            zc = (test_start === 5'h0) ? zc + 1 : 0;
        end
    endtask
    // Monitor event i; the benign variant sits just inside the limit
    task mon(input integer i, input bit b);
        @(posedge clock);
        case (i)
            0: ctrl_path_error <= b;
            1: {adc_valid, adc_filtered} <= {1'b1, 16'hf332 + b};
            2: {pre_add_valid, pre_add_a, pre_add_b} <= {1'b1, 16'h7fff, 15'h0, b};
            3: cordic_overflow <= b;
            default: sweep_start <= 1'b1;
        endcase
        @(posedge clock);
        {ctrl_path_error, adc_valid, pre_add_valid, cordic_overflow, sweep_start} <= 5'h0;
        range_hit <= (i == 4) && !b;
        clamp_hit <= (i == 4);
        @(posedge clock);
        clamp_hit <= 1'b0;
        range_hit <= 1'b0;
        repeat (3) @(posedge clock);
    endtask
    function [31:0] fbit(input integer i);
        case (i)
            0: fbit = 32'h1 << `FL_CTRL;
            1: fbit = 32'h1 << `FL_ADC;
            2: fbit = 32'h1 << `FL_ADDER;
            3: fbit = 32'h1 << `FL_CORDIC;
            default: fbit = 32'h1 << `FL_ANGRNG;
        endcase
    endfunction
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        rd_chk(`REG_SETTINGS, `SET_RESET);
        wr_reg(8'h14, 32'hffffffff);
        rd_chk(8'h14, 32'h0);
        run(2 * ROUND);
        chk("starts", 1, hi_cnt != 0);
        rd_chk(`REG_FLAGS, 32'h0);
        // Each failing test disabled alone stays silent
        for (k = 0; k < 5; k = k + 1) begin
            quiet;
            wr_reg(`REG_SETTINGS, 32'h1 | (32'h2 << k));
            quiet;
            bad <= 5'h1 << k;
            run(2 * ROUND);
            rd_chk(`REG_FLAGS, 32'h0);
            bad <= 5'h0;
        end
        quiet;
        wr_reg(`REG_SETTINGS, 32'h0);
        quiet;
        bad <= 5'h1f;
        run(2 * ROUND);
        chk("starts", 0, hi_cnt != 0);
        bad <= 5'h0;
        wr_reg(`REG_SETTINGS, 32'h7f01);
        for (k = 0; k < 5; k = k + 1) mon(k, 1'b1);
        rd_chk(`REG_FLAGS, 32'h0);
        chk("diag_req", 0, diag_req);
        wr_reg(`REG_SETTINGS, 32'h1);
        wr_reg(`REG_IRQ_MASK, 32'h1 << `FL_CTRL);
        expf = 32'h0;
        for (k = 0; k < 5; k = k + 1) begin
            mon(k, 1'b0);
            rd_chk(`REG_FLAGS, expf);
            mon(k, 1'b1);
            expf = expf | fbit(k);
            rd_chk(`REG_FLAGS, expf);
        end
        chk("irq", 1, irq);
        rd_chk(`REG_IRQ_STATUS, expf);
        rd_chk(`REG_IRQ_STATUS, 32'h0);
        chk("irq", 0, irq);
        chk("diag_req", 1, diag_req);
        // Each test failing in turn latches its own and the completion flag
        for (k = 0; k < 5; k = k + 1) begin
            quiet;
            bad <= 5'h1 << k;
            run(2 * ROUND);
            quiet;
            bad <= 5'h0;
            expf = expf | (32'h1 << k) | (32'h1 << `FL_COMPL);
            rd_chk(`REG_FLAGS, expf);
        end
        mute <= 5'h1;
        run(2 * ROUND);
        mute <= 5'h0;
        expf = expf | (32'h1 << `FL_NOREADY);
        rd_chk(`REG_FLAGS, expf);
        @(posedge clock) temp_sensor_fault <= 1'b1;
        @(posedge clock) temp_sensor_fault <= 1'b0;
        expf = expf | (32'h1 << `FL_TSENS);
        rd_chk(`REG_FLAGS, expf);
        finish_test;
    end
endmodule
